//--- iut_pkg.sv
// shared constants for the infrared uart timer and frame length register slice
package iut_pkg;
  // ==========================================================
  // register indexes within a bank; byte address is four times the index
  localparam logic [2:0] IDX_ADV_DIV_LO = 3'h0;
  localparam logic [2:0] IDX_ADV_DIV_HI = 3'h1;
  localparam logic [2:0] IDX_ADV_CTRL2 = 3'h4;
  localparam logic [2:0] IDX_TX_LEVEL = 3'h6;
  localparam logic [2:0] IDX_RX_LEVEL = 3'h7;
  localparam logic [2:0] IDX_VERSION = 3'h0;
  localparam logic [2:0] IDX_MAP_CTRL = 3'h1;
  localparam logic [2:0] IDX_MAP_FIFO = 3'h2;
  localparam logic [2:0] IDX_BANK_SEL = 3'h3;
  localparam logic [2:0] IDX_TMR_LO = 3'h0;
  localparam logic [2:0] IDX_TMR_HI = 3'h1;
  localparam logic [2:0] IDX_MODE_SEL = 3'h2;
  localparam logic [2:0] IDX_TXLEN_LO = 3'h4;
  localparam logic [2:0] IDX_TXLEN_HI = 3'h5;
  localparam logic [2:0] IDX_RXLEN_LO = 3'h6;
  localparam logic [2:0] IDX_RXLEN_HI = 3'h7;
  localparam int IDX_LSB = 2;
  // ==========================================================
  // register banks
  localparam logic [2:0] SET_0 = 3'h0;
  localparam logic [2:0] SET_2 = 3'h2;
  localparam logic [2:0] SET_3 = 3'h3;
  localparam logic [2:0] SET_4 = 3'h4;
  localparam logic [2:0] BANK_KEY = 3'h7;
  localparam int BANK_KEY_LSB = 5;
  localparam int BANK_NUM_LSB = 2;
  localparam logic [7:0] BANK_READ_SET2 = 8'he0;
  localparam logic [7:0] BANK_READ_SET3 = 8'he4;
  localparam logic [7:0] BANK_READ_SET4 = 8'he8;
  // version: upper nibble fixed, revision below (value arbitrary)
  localparam logic [3:0] VERSION_HIGH = 4'h1;
  // ==========================================================
  // field positions
  localparam int CTRL2_TXSZ_LSB = 0;
  localparam int CTRL2_RXSZ_LSB = 2;
  localparam int CTRL2_PREDIV_LSB = 4;
  localparam int CTRL2_NOFB_BIT = 7;
  localparam logic [7:0] CTRL2_MASK = 8'hbf;
  localparam int MODE_RUN_BIT = 0;
  localparam int MODE_TEST_BIT = 1;
  localparam int MODE_FIELD_LSB = 2;
  localparam logic [7:0] MODE_MASK = 8'h0f;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // ==========================================================
  // fifo sizes
  localparam logic [1:0] FSZ_16 = 2'b00;
  localparam logic [1:0] FSZ_32 = 2'b01;
  localparam logic [5:0] FIFO_DEPTH_16 = 6'h10;
  localparam logic [5:0] FIFO_DEPTH_32 = 6'h20;
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int TIMER_TICK_NS = 1000000;
  localparam int TIMER_TICK_CYCLES = TIMER_TICK_NS / CLK_PERIOD_NS;
  // ==========================================================
  typedef enum logic [1:0] {
    IUT_MODE_LEGACY,
    IUT_MODE_CONSUMER,
    IUT_MODE_ASK,
    IUT_MODE_SIR
  } iut_mode_t;
endpackage

//--- iut_regs.sv
// register bank slice of the advanced infrared uart: baud, timer and frame length
//
// Overview of operation
// - transmit fifo size field: 00 gives 16 bytes, 01 gives 32, 1x reserved.
// - baud generator divides pre-divided clock by the divisor into a 16x tick.
// - transmit fifo level register returns byte count in low six bits.
// - receive fifo level register returns byte count in low six bits.
// - read-only version register in set 3 offset 0, fixed upper nibble.
// - set 3 offset 1 mirrors set 0 infrared control, writes ignored.
// - set 3 offset 2 mirrors set 0 fifo control, read-only.
// - in set 3, offset 3 reads e4 and a write selects the bank.
// - in set 4, offset 3 reads e8 and a write selects the bank.
// - twelve-bit 1 ms down timer starts when its run bit is written 1.
// - at zero while running, set the expiry flag and reload the counter.
// - test bit makes timer byte reads return the reload value.
// - mode field: legacy, consumer, legacy ask and legacy sir.
// - transmit frame length is thirteen bits, active only with auto packets.
// - auto packet mode cuts long transmit data into frames of that length.
// - transmit length read returns bytes of the frame not yet sent.
// - receive length is a thirteen-bit limit with an up counter of bytes.
// - overlength sets the flag and blocks fifo writes until next frame start.
// - receive length read returns bytes of the current frame written to the fifo.
// - no-fallback bit stops legacy divisor access forcing legacy sir mode.
// - frame-end mode bit enables equal-length transmit frame splitting.
// - overlength flag goes to the frame status entry, valid when ready.
//
// The implementer's own choice: the AHB-Lite slave port.
`timescale 1ns/1ps
module iut_regs
  import iut_pkg::*;
#(
  parameter int MS_CYCLES = TIMER_TICK_CYCLES
) (
  // clock and reset
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  // ahb-lite slave
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  // set 0 registers held elsewhere
  input wire logic [7:0] IR_CONTROL_I,
  input wire logic [7:0] IR_FIFO_CONTROL_I,
  input wire logic FRAME_END_AUTO_I,
  input wire logic LEGACY_DIV_ACCESS_I,
  output logic [2:0] ACTIVE_SET_O,
  output logic FALLBACK_O,
  // fifo sizing and levels
  input wire logic [5:0] TX_FIFO_LEVEL_I,
  input wire logic [5:0] RX_FIFO_LEVEL_I,
  output logic [5:0] TX_FIFO_DEPTH_O,
  output logic [1:0] RX_FIFO_SIZE_SEL_O,
  // baud generation
  input wire logic PREDIV_TICK_I,
  output logic [1:0] PRE_DIV_SEL_O,
  output logic BAUD16_TICK_O,
  output logic [1:0] INFRARED_MODE_O,
  // timer
  input wire logic TIMER_FLAG_CLR_I,
  output logic TIMER_EXPIRED_O,
  // transmit framing
  input wire logic TX_BYTE_SENT_I,
  output logic TX_FRAME_END_O,
  // receive framing
  input wire logic RX_FRAME_START_I,
  input wire logic RX_BYTE_I,
  input wire logic STATUS_ENTRY_PUSH_I,
  output logic RX_FIFO_WRITE_O,
  output logic FRAME_TOO_LONG_O,
  output logic STATUS_TOO_LONG_O
);
  // ==========================================================
  // bus address phase capture
  logic wr_pend_q;
  logic [2:0] wr_idx_q;
  logic [2:0] active_set_q;
  logic [31:0] rdata_q;
  logic addr_ok;
  logic take;
  logic [2:0] rd_idx;
  logic [7:0] rd_byte;
  logic [7:0] wbyte;
  logic in_set2;
  logic in_set3;
  logic in_set4;

  assign addr_ok = (HADDR_I[31:5] == 27'h0);
  assign take = HSEL_I && HREADY_I && HTRANS_I[1];
  assign rd_idx = HADDR_I[IDX_LSB +: 3];
  assign wbyte = HWDATA_I[7:0];
  assign in_set2 = (active_set_q == SET_2);
  assign in_set3 = (active_set_q == SET_3);
  assign in_set4 = (active_set_q == SET_4);

  // zero wait state: every transfer finishes in its first data-phase cycle
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O = 1'b0;
  assign HRDATA_O = rdata_q;

  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      wr_pend_q <= 1'b0;
      wr_idx_q <= 3'h0;
    end else begin
      wr_pend_q <= take && HWRITE_I && addr_ok;
      wr_idx_q <= rd_idx;
    end
  end

  // write strobes, valid in the data phase
  logic we_bank;
  logic we_div_lo;
  logic we_div_hi;
  logic we_ctrl2;
  logic we_tmr_lo;
  logic we_tmr_hi;
  logic we_mode;
  logic we_txl_lo;
  logic we_txl_hi;
  logic we_rxl_lo;
  logic we_rxl_hi;

  assign we_bank = wr_pend_q && (wr_idx_q == IDX_BANK_SEL);
  assign we_div_lo = wr_pend_q && in_set2 && (wr_idx_q == IDX_ADV_DIV_LO);
  assign we_div_hi = wr_pend_q && in_set2 && (wr_idx_q == IDX_ADV_DIV_HI);
  assign we_ctrl2 = wr_pend_q && in_set2 && (wr_idx_q == IDX_ADV_CTRL2);
  assign we_tmr_lo = wr_pend_q && in_set4 && (wr_idx_q == IDX_TMR_LO);
  assign we_tmr_hi = wr_pend_q && in_set4 && (wr_idx_q == IDX_TMR_HI);
  assign we_mode = wr_pend_q && in_set4 && (wr_idx_q == IDX_MODE_SEL);
  assign we_txl_lo = wr_pend_q && in_set4 && (wr_idx_q == IDX_TXLEN_LO);
  assign we_txl_hi = wr_pend_q && in_set4 && (wr_idx_q == IDX_TXLEN_HI);
  assign we_rxl_lo = wr_pend_q && in_set4 && (wr_idx_q == IDX_RXLEN_LO);
  assign we_rxl_hi = wr_pend_q && in_set4 && (wr_idx_q == IDX_RXLEN_HI);

  // ==========================================================
  // bank select: keyed writes pick sets 2..5, anything else returns to set 0
  logic [2:0] bank_d;

  assign bank_d = (wbyte[BANK_KEY_LSB +: 3] == BANK_KEY) ?
                  3'(wbyte[BANK_NUM_LSB +: 2]) + SET_2 : SET_0;
  assign ACTIVE_SET_O = active_set_q;

  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      active_set_q <= SET_0;
    end else if (we_bank) begin
      active_set_q <= bank_d;
    end
  end

  // ==========================================================
  // set 2: advanced divisor and control 2
  logic [15:0] adv_div_q;
  logic [7:0] ctrl2_q;

  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      adv_div_q <= 16'h0;
      ctrl2_q <= RESET_BYTE;
    end else begin
      if (we_div_lo) begin
        adv_div_q[7:0] <= wbyte;
      end
      if (we_div_hi) begin
        adv_div_q[15:8] <= wbyte;
      end
      if (we_ctrl2) begin
        ctrl2_q <= wbyte & CTRL2_MASK;
      end
    end
  end

  // reserved size codes fall back to the 16-byte fifo
  assign TX_FIFO_DEPTH_O = (ctrl2_q[CTRL2_TXSZ_LSB +: 2] == FSZ_32) ?
                           FIFO_DEPTH_32 : FIFO_DEPTH_16;
  assign RX_FIFO_SIZE_SEL_O = ctrl2_q[CTRL2_RXSZ_LSB +: 2];
  assign PRE_DIV_SEL_O = ctrl2_q[CTRL2_PREDIV_LSB +: 2];
  assign FALLBACK_O = LEGACY_DIV_ACCESS_I && !ctrl2_q[CTRL2_NOFB_BIT];

  // ==========================================================
  // baud generator: one 16x tick per divisor pre-divided ticks; divisor 0 stops it
  logic [15:0] baud_cnt_q;
  logic baud_tick_q;
  logic baud_wrap;

  assign baud_wrap = (baud_cnt_q >= adv_div_q - 16'h1);

  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      baud_cnt_q <= 16'h0;
      baud_tick_q <= 1'b0;
    end else begin
      baud_tick_q <= 1'b0;
      if (we_div_lo || we_div_hi) begin
        baud_cnt_q <= 16'h0;
      end else if (PREDIV_TICK_I && adv_div_q != 16'h0) begin
        baud_cnt_q <= baud_wrap ? 16'h0 : baud_cnt_q + 16'h1;
        baud_tick_q <= baud_wrap;
      end
    end
  end

  assign BAUD16_TICK_O = baud_tick_q;

  // ==========================================================
  // mode select and millisecond timer
  logic [3:0] mode_q;
  logic [11:0] tmr_reload_q;
  logic [11:0] tmr_cnt_q;
  logic [$clog2(MS_CYCLES)-1:0] ms_cnt_q;
  logic tmr_flag_q;
  logic tmr_run;
  logic ms_tick;
  logic run_rise;
  logic tmr_zero_hit;
  iut_mode_t ir_mode;

  assign tmr_run = mode_q[MODE_RUN_BIT];
  assign ir_mode = iut_mode_t'(mode_q[MODE_FIELD_LSB +: 2]);
  assign INFRARED_MODE_O = ir_mode;
  assign ms_tick = tmr_run && (ms_cnt_q == ($clog2(MS_CYCLES))'(MS_CYCLES - 1));
  assign run_rise = we_mode && wbyte[MODE_RUN_BIT] && !tmr_run;
  assign tmr_zero_hit = ms_tick && (tmr_cnt_q == 12'h0);

  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      mode_q <= 4'h0;
    end else if (we_mode) begin
      mode_q <= 4'(wbyte & MODE_MASK);
    end
  end

  // prescaler only runs while the timer runs, so each count is a full 1 ms
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I || !tmr_run) begin
      ms_cnt_q <= '0;
    end else begin
      ms_cnt_q <= ms_tick ? '0 : ms_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      tmr_reload_q <= 12'h0;
    end else begin
      if (we_tmr_lo) begin
        tmr_reload_q[7:0] <= wbyte;
      end
      if (we_tmr_hi) begin
        tmr_reload_q[11:8] <= wbyte[3:0];
      end
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      tmr_cnt_q <= 12'h0;
    end else if (run_rise) begin
      tmr_cnt_q <= tmr_reload_q;
    end else if (tmr_zero_hit) begin
      tmr_cnt_q <= tmr_reload_q;
    end else if (ms_tick) begin
      tmr_cnt_q <= tmr_cnt_q - 12'h1;
    end
  end

  // set beats clear when both land in one cycle
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      tmr_flag_q <= 1'b0;
    end else if (tmr_zero_hit) begin
      tmr_flag_q <= 1'b1;
    end else if (TIMER_FLAG_CLR_I) begin
      tmr_flag_q <= 1'b0;
    end
  end

  assign TIMER_EXPIRED_O = tmr_flag_q;

  logic [11:0] tmr_view;

  assign tmr_view = mode_q[MODE_TEST_BIT] ? tmr_reload_q : tmr_cnt_q;

  // ==========================================================
  // transmit frame length: remaining count reloads at each frame boundary
  logic [12:0] txl_prog_q;
  logic [12:0] tx_left_q;
  logic tx_end_q;
  logic tx_split;
  logic tx_last;

  assign tx_split = FRAME_END_AUTO_I;
  assign tx_last = (tx_left_q == 13'h1) || (tx_left_q == 13'h0);

  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      txl_prog_q <= 13'h0;
    end else begin
      if (we_txl_lo) begin
        txl_prog_q[7:0] <= wbyte;
      end
      if (we_txl_hi) begin
        txl_prog_q[12:8] <= wbyte[4:0];
      end
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      tx_left_q <= 13'h0;
      tx_end_q <= 1'b0;
    end else begin
      tx_end_q <= 1'b0;
      if (we_txl_lo || we_txl_hi || !tx_split) begin
        tx_left_q <= txl_prog_q;
      end else if (TX_BYTE_SENT_I) begin
        tx_left_q <= tx_last ? txl_prog_q : tx_left_q - 13'h1;
        tx_end_q <= tx_last;
      end
    end
  end

  assign TX_FRAME_END_O = tx_end_q;

  // ==========================================================
  // receive frame length: byte counter against the programmed limit
  logic [12:0] rxl_lim_q;
  logic [12:0] rx_cnt_q;
  logic too_long_q;
  logic status_long_q;
  logic rx_over;

  assign rx_over = RX_BYTE_I && !RX_FRAME_START_I && (rx_cnt_q >= rxl_lim_q);
  assign RX_FIFO_WRITE_O = RX_BYTE_I && (RX_FRAME_START_I ||
                           (!too_long_q && !rx_over));

  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      rxl_lim_q <= 13'h0;
    end else begin
      if (we_rxl_lo) begin
        rxl_lim_q[7:0] <= wbyte;
      end
      if (we_rxl_hi) begin
        rxl_lim_q[12:8] <= wbyte[4:0];
      end
    end
  end

  // a start flag opens a fresh frame; a byte in that cycle is its first byte
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      rx_cnt_q <= 13'h0;
      too_long_q <= 1'b0;
    end else if (RX_FRAME_START_I) begin
      rx_cnt_q <= {12'h0, RX_BYTE_I};
      too_long_q <= 1'b0;
    end else if (rx_over) begin
      too_long_q <= 1'b1;
    end else if (RX_BYTE_I && !too_long_q) begin
      rx_cnt_q <= rx_cnt_q + 13'h1;
    end
  end

  // the flag is copied into the status entry when the frame's entry is pushed
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      status_long_q <= 1'b0;
    end else if (STATUS_ENTRY_PUSH_I) begin
      status_long_q <= too_long_q || rx_over;
    end
  end

  assign FRAME_TOO_LONG_O = too_long_q;
  assign STATUS_TOO_LONG_O = status_long_q;

  // ==========================================================
  // read multiplexer, reserved offsets return zero
  always_comb begin
    rd_byte = 8'h00;
    if (in_set2) begin
      unique case (rd_idx)
        IDX_ADV_DIV_LO: rd_byte = adv_div_q[7:0];
        IDX_ADV_DIV_HI: rd_byte = adv_div_q[15:8];
        IDX_BANK_SEL: rd_byte = BANK_READ_SET2;
        IDX_ADV_CTRL2: rd_byte = ctrl2_q;
        IDX_TX_LEVEL: rd_byte = {2'b00, TX_FIFO_LEVEL_I};
        IDX_RX_LEVEL: rd_byte = {2'b00, RX_FIFO_LEVEL_I};
        default: rd_byte = 8'h00;
      endcase
    end else if (in_set3) begin
      unique case (rd_idx)
        IDX_VERSION: rd_byte = {VERSION_HIGH, 4'h0};
        IDX_MAP_CTRL: rd_byte = IR_CONTROL_I;
        IDX_MAP_FIFO: rd_byte = IR_FIFO_CONTROL_I;
        IDX_BANK_SEL: rd_byte = BANK_READ_SET3;
        default: rd_byte = 8'h00;
      endcase
    end else if (in_set4) begin
      unique case (rd_idx)
        IDX_TMR_LO: rd_byte = tmr_view[7:0];
        IDX_TMR_HI: rd_byte = {4'h0, tmr_view[11:8]};
        IDX_MODE_SEL: rd_byte = {4'h0, mode_q};
        IDX_BANK_SEL: rd_byte = BANK_READ_SET4;
        IDX_TXLEN_LO: rd_byte = tx_left_q[7:0];
        IDX_TXLEN_HI: rd_byte = {3'h0, tx_left_q[12:8]};
        IDX_RXLEN_LO: rd_byte = rx_cnt_q[7:0];
        IDX_RXLEN_HI: rd_byte = {3'h0, rx_cnt_q[12:8]};
        default: rd_byte = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      rdata_q <= 32'h0;
    end else if (take && !HWRITE_I) begin
      rdata_q <= addr_ok ? {24'h0, rd_byte} : 32'h0;
    end
  end

endmodule

//--- iut_regs_asserts.sv
// port checker for the infrared uart register slice
`timescale 1ns/1ps
module iut_regs_asserts
  import iut_pkg::*;
(
  // clock, reset and bus
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  input wire logic [31:0] HRDATA_O,
  input wire logic [2:0] ACTIVE_SET_O,
  // side signals
  input wire logic [5:0] TX_FIFO_DEPTH_O,
  input wire logic LEGACY_DIV_ACCESS_I,
  input wire logic FALLBACK_O,
  input wire logic PREDIV_TICK_I,
  input wire logic BAUD16_TICK_O,
  input wire logic TIMER_FLAG_CLR_I,
  input wire logic TIMER_EXPIRED_O,
  input wire logic FRAME_END_AUTO_I,
  input wire logic TX_BYTE_SENT_I,
  input wire logic TX_FRAME_END_O,
  input wire logic RX_FRAME_START_I,
  input wire logic RX_BYTE_I,
  input wire logic RX_FIFO_WRITE_O,
  input wire logic FRAME_TOO_LONG_O
);
  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (!RST_N_I);
  // ==========================================================
  // bus and configuration
  property p_bank4;
    HSEL_I && HREADY_I && HTRANS_I[1] && HWRITE_I && HADDR_I == 32'h0000000c
      ##1 HWDATA_I[7:0] == BANK_READ_SET4 |=> ACTIVE_SET_O == SET_4;
  endproperty
  a_bank4: assert property (p_bank4) else $error("set 4 not selected");
  property p_hi_zero;
    HRDATA_O[31:8] == 24'h0;
  endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("read data upper bits set");
  property p_depth;
    TX_FIFO_DEPTH_O == FIFO_DEPTH_16 || TX_FIFO_DEPTH_O == FIFO_DEPTH_32;
  endproperty
  a_depth: assert property (p_depth) else $error("fifo depth not 16 or 32");
  property p_fallback;
    FALLBACK_O |-> LEGACY_DIV_ACCESS_I;
  endproperty
  a_fallback: assert property (p_fallback) else $error("fallback without access");
  // ==========================================================
  // baud, timer and framing
  property p_baud;
    BAUD16_TICK_O |-> $past(PREDIV_TICK_I);
  endproperty
  a_baud: assert property (p_baud) else $error("baud tick without input tick");
  property p_flag_hold;
    TIMER_EXPIRED_O && !TIMER_FLAG_CLR_I |=> TIMER_EXPIRED_O;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("timer flag lost");
  property p_frame_end;
    TX_FRAME_END_O |-> $past(TX_BYTE_SENT_I) && $past(FRAME_END_AUTO_I);
  endproperty
  a_frame_end: assert property (p_frame_end) else $error("stray frame end");
  property p_rx_write;
    RX_FIFO_WRITE_O |-> RX_BYTE_I && (!FRAME_TOO_LONG_O || RX_FRAME_START_I);
  endproperty
  a_rx_write: assert property (p_rx_write) else $error("write while too long");
endmodule
bind iut_regs iut_regs_asserts chk (
  .CORE_CLK_I(CORE_CLK_I), .RST_N_I(RST_N_I), .HSEL_I(HSEL_I), .HADDR_I(HADDR_I),
  .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HWDATA_I(HWDATA_I), .HREADY_I(HREADY_I),
  .HRDATA_O(HRDATA_O), .ACTIVE_SET_O(ACTIVE_SET_O), .TX_FIFO_DEPTH_O(TX_FIFO_DEPTH_O),
  .LEGACY_DIV_ACCESS_I(LEGACY_DIV_ACCESS_I), .FALLBACK_O(FALLBACK_O),
  .PREDIV_TICK_I(PREDIV_TICK_I), .BAUD16_TICK_O(BAUD16_TICK_O),
  .TIMER_FLAG_CLR_I(TIMER_FLAG_CLR_I), .TIMER_EXPIRED_O(TIMER_EXPIRED_O),
  .FRAME_END_AUTO_I(FRAME_END_AUTO_I), .TX_BYTE_SENT_I(TX_BYTE_SENT_I),
  .TX_FRAME_END_O(TX_FRAME_END_O), .RX_FRAME_START_I(RX_FRAME_START_I),
  .RX_BYTE_I(RX_BYTE_I), .RX_FIFO_WRITE_O(RX_FIFO_WRITE_O),
  .FRAME_TOO_LONG_O(FRAME_TOO_LONG_O));

//--- iut_link_model.sv
// behavioural infrared transceiver pacing bytes on both link directions
`timescale 1ns/1ps
module iut_link_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // commands from the bench
  input wire logic rx_go_i,
  input wire logic tx_go_i,
  input wire logic pre_en_i,
  input wire logic [3:0] len_i,
  // link events towards the block
  output logic start_o,
  output logic byte_o,
  output logic sent_o,
  output logic prediv_o,
  output logic busy_o
);
  logic [3:0] left_q;
  logic [1:0] ph_q;
  logic rx_q;
  // ==========================================================
  // one byte every four cycles; a received frame opens with its start flag
  always_ff @(posedge clk_i) begin
    start_o <= 1'b0;
    byte_o <= 1'b0;
    sent_o <= 1'b0;
    prediv_o <= pre_en_i & ~prediv_o;
    if (!rst_n_i) begin
      busy_o <= 1'b0;
      prediv_o <= 1'b0;
    end else if (rx_go_i || tx_go_i) begin
      busy_o <= 1'b1;
      left_q <= len_i;
      ph_q <= 2'h0;
      rx_q <= rx_go_i;
      start_o <= rx_go_i;
    end else if (busy_o) begin
      ph_q <= ph_q + 2'h1;
      if (ph_q == 2'h3) begin
        busy_o <= left_q != 4'h0;
        left_q <= left_q - 4'h1;
        byte_o <= rx_q && left_q != 4'h0;
        sent_o <= !rx_q && left_q != 4'h0;
      end
    end
  end
endmodule

//--- iut_tb.sv
// self-checking bench for the infrared uart register slice
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
  $display("Error %s expected %0h seen %0h", n, e, g); end end
module testbench;
  import iut_pkg::*;
  // ==========================================================
  // stimulus and observed signals
  logic clk = 0, rst_n = 0, hsel = 0, hwrite = 0, leg = 0, clr = 0, fea = 0, push = 0;
  logic rx_go = 0, tx_go = 0, pre_en = 0, rd_ph = 0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [26:0] page = 27'h0;
  logic [7:0] ctl = 8'h0, fctl = 8'h0, e_rd, exp_q[$];
  logic [5:0] txl = 6'h0, rxl = 6'h0, depth;
  logic [3:0] len = 4'h0;
  logic [2:0] aset;
  logic [1:0] mode, rsz, pdv;
  logic hready, fb, baud, texp, fend, rxw, tlong, stlong, st, rb, sent, pre, busy, hresp;
  int bad_count = 0, samples_checked = 0, n_wr = 0, n_fe = 0, n_bd = 0, n_pre = 0;
  int dv[4] = '{0, 1, 3, 7};
  int k, b0, p0;
  always #20 clk = ~clk;
  iut_regs #(.MS_CYCLES(10)) uut (
    .CORE_CLK_I(clk), .RST_N_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
    .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready),
    .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp), .IR_CONTROL_I(ctl),
    .IR_FIFO_CONTROL_I(fctl), .FRAME_END_AUTO_I(fea), .LEGACY_DIV_ACCESS_I(leg),
    .ACTIVE_SET_O(aset), .FALLBACK_O(fb), .TX_FIFO_LEVEL_I(txl), .RX_FIFO_LEVEL_I(rxl),
    .TX_FIFO_DEPTH_O(depth), .RX_FIFO_SIZE_SEL_O(rsz), .PREDIV_TICK_I(pre), .PRE_DIV_SEL_O(pdv),
    .BAUD16_TICK_O(baud), .INFRARED_MODE_O(mode), .TIMER_FLAG_CLR_I(clr),
    .TIMER_EXPIRED_O(texp), .TX_BYTE_SENT_I(sent), .TX_FRAME_END_O(fend),
    .RX_FRAME_START_I(st), .RX_BYTE_I(rb), .STATUS_ENTRY_PUSH_I(push), .RX_FIFO_WRITE_O(rxw),
    .FRAME_TOO_LONG_O(tlong), .STATUS_TOO_LONG_O(stlong));
  iut_link_model link (.clk_i(clk), .rst_n_i(rst_n), .rx_go_i(rx_go), .tx_go_i(tx_go),
    .pre_en_i(pre_en), .len_i(len), .start_o(st), .byte_o(rb), .sent_o(sent),
    .prediv_o(pre), .busy_o(busy));
  // ==========================================================
  // monitor: read data against the oldest note, event counters
  always @(posedge clk) begin
    if (rd_ph) begin
      e_rd = exp_q.pop_front();
      `CHK("read data", {1'b0, 24'h0, e_rd}, {hresp, hrdata})
    end
    rd_ph <= hsel && htrans[1] && !hwrite && hready;
    n_wr <= n_wr + int'(rxw);
    n_fe <= n_fe + int'(fend);
    n_bd <= n_bd + int'(baud);
    n_pre <= n_pre + int'(pre);
  end
  // ==========================================================
  // bus and link tasks
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic lapse(input int n, input int lim);
    if (n >= lim) begin
      bad_count++;
      tally_and_finish();
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic edge_rdy();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 64);
    lapse(n, 64);
  endtask
  // one word transfer; a read notes d as the byte it expects
  task automatic bus(input logic w, input logic [2:0] idx, input logic [7:0] d);
    logic [31:0] r;
    r = $urandom();
    hsel <= 1'b1;
    haddr <= {page, idx, 2'b00};
    hwrite <= w;
    htrans <= 2'b10;
    edge_rdy();
    if (!w) exp_q.push_back(d);
    htrans <= 2'b00;
    hwdata <= {r[31:8], d};
    edge_rdy();
  endtask
  task automatic frame(input logic rx, input logic [3:0] n);
    rx_go <= rx;
    tx_go <= !rx;
    len <= n;
    tick(1);
    rx_go <= 1'b0;
    tx_go <= 1'b0;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (busy !== 1'b0 && k < 100);
    lapse(k, 100);
    tick(3);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(8677));
    {ctl, fctl, txl, rxl} <= 28'($urandom());
    tick(8);
    rst_n <= 1'b1;
    tick(1);
    bus(1, IDX_BANK_SEL, BANK_READ_SET3);
    bus(0, IDX_BANK_SEL, 8'he4);
    bus(0, IDX_VERSION, {VERSION_HIGH, 4'h0});
    bus(1, IDX_MAP_CTRL, ~ctl);
    bus(1, IDX_MAP_FIFO, ~fctl);
    bus(0, IDX_MAP_CTRL, ctl);
    bus(0, IDX_MAP_FIFO, fctl);
    for (int i = 4; i < 8; i++) bus(0, 3'(i), 8'h00);
    // high address bits set: outside the map, so the bank must not move
    page = 27'h1;
    bus(1, IDX_BANK_SEL, BANK_READ_SET2);
    bus(0, IDX_BANK_SEL, 8'h00);
    page = 27'h0;
    `CHK("active set", SET_3, aset)
    bus(1, IDX_BANK_SEL, BANK_READ_SET2);
    bus(0, IDX_TX_LEVEL, {2'b00, txl});
    bus(0, IDX_RX_LEVEL, {2'b00, rxl});
    for (int c = 0; c < 4; c++) begin
      bus(1, IDX_ADV_CTRL2, 8'hc0 | 8'(c * 21));
      bus(0, IDX_ADV_CTRL2, 8'h80 | 8'(c * 21));
      `CHK("fifo depth", (c == 1) ? FIFO_DEPTH_32 : FIFO_DEPTH_16, depth)
      `CHK("rx size and prediv", {2'(c), 2'(c)}, {rsz, pdv})
    end
    for (int f = 0; f < 2; f++) begin
      bus(1, IDX_ADV_CTRL2, {1'(f), 7'h0});
      leg <= 1'b1;
      tick(1);
      `CHK("fallback", f == 0, fb)
      leg <= 1'b0;
    end
    foreach (dv[i]) begin
      bus(1, IDX_ADV_DIV_LO, 8'(dv[i]));
      b0 = n_bd;
      p0 = n_pre;
      pre_en <= 1'b1;
      tick(40);
      pre_en <= 1'b0;
      tick(4);
      `CHK("baud ticks", (dv[i] == 0) ? 0 : (n_pre - p0) / dv[i], n_bd - b0)
    end
    bus(1, IDX_BANK_SEL, BANK_READ_SET4);
    bus(0, IDX_BANK_SEL, 8'he8);
    bus(0, IDX_MODE_SEL, 8'h00);
    for (int m = 0; m < 4; m++) begin
      bus(1, IDX_MODE_SEL, {4'hf, 2'(m), 2'b00});
      bus(0, IDX_MODE_SEL, {4'h0, 2'(m), 2'b00});
      `CHK("ir mode", 2'(m), mode)
    end
    bus(1, IDX_TMR_LO, 8'h03);
    bus(1, IDX_TMR_HI, 8'h00);
    bus(1, IDX_MODE_SEL, 8'h02);
    bus(0, IDX_TMR_LO, 8'h03);
    bus(1, IDX_MODE_SEL, 8'h01);
    k = 0;
    while (texp !== 1'b1 && k < 200) begin
      @(posedge clk);
      k++;
    end
    lapse(k, 200);
    `CHK("expiry time", 1'b1, k >= 35 && k <= 45)
    bus(0, IDX_TMR_LO, 8'h03);
    bus(1, IDX_MODE_SEL, 8'h00);
    clr <= 1'b1;
    tick(1);
    clr <= 1'b0;
    tick(100);
    `CHK("timer flag", 1'b0, texp)
    bus(0, IDX_TMR_LO, 8'h03);
    bus(1, IDX_TXLEN_LO, 8'h04);
    bus(1, IDX_TXLEN_HI, 8'h00);
    bus(0, IDX_TXLEN_LO, 8'h04);
    fea <= 1'b1;
    b0 = n_fe;
    frame(1'b0, 4'h6);
    `CHK("frame ends", 1, n_fe - b0)
    bus(0, IDX_TXLEN_LO, 8'h02);
    bus(1, IDX_RXLEN_LO, 8'h03);
    bus(1, IDX_RXLEN_HI, 8'h00);
    b0 = n_wr;
    frame(1'b1, 4'h5);
    `CHK("fifo writes", 3, n_wr - b0)
    `CHK("too long", 1'b1, tlong)
    bus(0, IDX_RXLEN_LO, 8'h03);
    push <= 1'b1;
    tick(1);
    push <= 1'b0;
    tick(1);
    `CHK("status too long", 1'b1, stlong)
    b0 = n_wr;
    frame(1'b1, 4'h2);
    `CHK("fifo writes", 2, n_wr - b0)
    `CHK("too long", 1'b0, tlong)
    bus(0, IDX_RXLEN_LO, 8'h02);
    bus(1, IDX_BANK_SEL, 8'h00);
    bus(0, IDX_BANK_SEL, 8'h00);
    `CHK("active set", SET_0, aset)
    tally_and_finish();
  end
endmodule
